// ==== rtl/vam_angle_hold_unit.sv ====
// voltage angle hold unit with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none

module vam_angle_hold_unit #(
    parameter int unsigned CYCLE_CLKS = vam_pkg::CYCLE_CLKS,
    parameter int unsigned DW         = vam_pkg::DW
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire logic [2:0][DW-1:0]    volt_mag,
    input  wire logic [2:0][DW-1:0]    volt_ang,
    input  wire logic [2:0][DW-1:0]    curr_mag,
    input  wire logic                  hold_block,
    output logic                       mem_active,
    output logic [DW-1:0]              ref_amp,
    output logic [2:0][DW-1:0]         ref_ang,
    output logic                       prot_block,
    output logic                       trip_clear,
    output logic                       irq
);
    localparam int unsigned NIRQ = vam_pkg::NIRQ;
    localparam int unsigned CW   = $clog2(CYCLE_CLKS + 1);
    localparam int unsigned HW   = $clog2(vam_pkg::HEALTHY_CYC + 2);

    // ---------------- bus slave ----------------
    logic             wr_pend_q;
    logic [7:0]       wr_addr_q;
    logic [4:0]       ctrl_q;
    logic [DW-1:0]    thresh_q;
    logic [DW-1:0]    mincur_q;
    logic [DW-1:0]    maxhold_q;
    logic [NIRQ-1:0]  int_stat_q;
    logic [NIRQ-1:0]  int_en_q;
    logic [NIRQ-1:0]  int_clr;
    logic [NIRQ-1:0]  int_set;
    logic [4:0]       status;
    logic             addr_ok;

    assign addr_ok = hsel & htrans[1] & hready;

    function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                           input logic [4:0] st);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            vam_pkg::OFS_CTRL:     r[4:0]    = ctrl_q;
            vam_pkg::OFS_THRESH:   r[DW-1:0] = thresh_q;
            vam_pkg::OFS_MINCUR:   r[DW-1:0] = mincur_q;
            vam_pkg::OFS_MAXHOLD:  r[DW-1:0] = maxhold_q;
            vam_pkg::OFS_STATUS:   r[4:0]    = st;
            vam_pkg::OFS_INT_STAT: r[NIRQ-1:0] = int_stat_q;
            vam_pkg::OFS_INT_EN:   r[NIRQ-1:0] = int_en_q;
            default:               r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // zero wait state: read data captured at the address phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
            end
            if (addr_ok & ~hwrite) begin
                hrdata <= rd_mux(haddr[7:0], status);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q    <= vam_pkg::CTRL_RST;
            thresh_q  <= vam_pkg::THRESH_RST;
            mincur_q  <= vam_pkg::MINCUR_RST;
            maxhold_q <= vam_pkg::MAXHOLD_RST;
            int_en_q  <= '0;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                vam_pkg::OFS_CTRL:    ctrl_q    <= hwdata[4:0];
                vam_pkg::OFS_THRESH:  thresh_q  <= hwdata[DW-1:0];
                vam_pkg::OFS_MINCUR:  mincur_q  <= hwdata[DW-1:0];
                vam_pkg::OFS_MAXHOLD: maxhold_q <= hwdata[DW-1:0];
                vam_pkg::OFS_INT_EN:  int_en_q  <= hwdata[NIRQ-1:0];
                default: ;
            endcase
        end
    end

    assign int_clr = (wr_pend_q && wr_addr_q == vam_pkg::OFS_INT_CLR)
                   ? hwdata[NIRQ-1:0] : '0;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_stat_q <= '0;
            irq        <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_set;
            irq        <= |(((int_stat_q & ~int_clr) | int_set)
                            & int_en_q);
        end
    end

    // ---------------- processing cycle ----------------
    logic          en;
    logic          cur_cond_en;
    logic [2:0]    used;
    logic [CW-1:0] div_q;
    logic          tick_q;
    logic          blk_m_q;
    logic          blk_s_q;
    logic          blk_cyc_q;

    assign en          = ctrl_q[vam_pkg::CTRL_EN_BIT];
    assign cur_cond_en = ctrl_q[vam_pkg::CTRL_CUR_BIT];
    assign used        = ctrl_q[vam_pkg::CTRL_USED_LSB +: 3];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == CW'(CYCLE_CLKS - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // block pin is asynchronous: two flops, then per-cycle sample
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            blk_m_q   <= 1'b0;
            blk_s_q   <= 1'b0;
            blk_cyc_q <= 1'b0;
        end else begin
            blk_m_q <= hold_block;
            blk_s_q <= blk_m_q;
            // held for the whole cycle, so the fsm acts one tick later
            if (tick_q) begin
                blk_cyc_q <= blk_s_q;
            end
        end
    end

    // ---------------- criteria ----------------
    logic          volt_low;
    logic          volt_healthy;
    logic          cur_high;
    logic          cur_ok;
    logic          armed;
    logic [HW-1:0] healthy_q;

    function automatic logic all_below(input logic [2:0][DW-1:0] m,
                                       input logic [2:0] u,
                                       input logic [DW-1:0] t);
        logic r;
        r = |u;
        for (int i = 0; i < 3; i++) begin
            if (u[i] && m[i] >= t) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    function automatic logic any_above(input logic [2:0][DW-1:0] m,
                                       input logic [DW-1:0] t);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (m[i] > t) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic healthy_chk(input logic [2:0][DW-1:0] m,
                                         input logic [2:0] u,
                                         input logic [DW-1:0] t);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (u[i] && m[i] < t) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    assign volt_low = all_below(volt_mag, used, thresh_q);
    // healthy: no used channel under the threshold
    // a used mask of 0 is never healthy, so the unit never arms
    assign volt_healthy = (|used) & healthy_chk(volt_mag, used, thresh_q);
    assign cur_high = any_above(curr_mag, mincur_q);
    assign cur_ok   = ~cur_cond_en | cur_high;
    assign armed    = healthy_q > HW'(vam_pkg::HEALTHY_CYC);

    // ---------------- angle tracking ----------------
    logic [2:0][DW-1:0] track_q;
    logic [2:0][DW-1:0] held_q;

    // only healthy cycles update, so collapse leaves the pre-fault angle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            track_q <= '0;
        end else if (tick_q && volt_healthy) begin
            track_q <= volt_ang;
        end
    end

    // ---------------- hold state machine ----------------
    vam_pkg::vam_state_t state_q;
    logic [DW-1:0]       hold_cnt_q;
    logic                go;

    assign go = en & ~blk_cyc_q & armed & volt_low & cur_ok;

    // counter saturates; once earned the arm outlives the collapse, so
    // a late current rise still activates; each activation spends it
    // limitation: a long partial dip keeps an earned arm alive
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            healthy_q <= '0;
        end else if (tick_q) begin
            if (state_q == vam_pkg::VAM_IDLE && go) begin
                healthy_q <= '0;
            end else if (!volt_healthy) begin
                if (!armed) begin
                    healthy_q <= '0;
                end
            end else if (!armed) begin
                healthy_q <= healthy_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q    <= vam_pkg::VAM_IDLE;
            hold_cnt_q <= '0;
            held_q     <= '0;
            int_set    <= '0;
            trip_clear <= 1'b0;
        end else begin
            int_set    <= '0;
            trip_clear <= 1'b0;
            if (tick_q) begin
                case (state_q)
                    vam_pkg::VAM_IDLE: begin
                        hold_cnt_q <= '0;
                        if (go) begin
                            state_q <= vam_pkg::VAM_ACTIVE;
                            held_q  <= track_q;
                            int_set[vam_pkg::IRQ_ON_BIT] <= 1'b1;
                        end
                    end
                    vam_pkg::VAM_ACTIVE: begin
                        if (!en || blk_cyc_q || !volt_low) begin
                            state_q <= vam_pkg::VAM_IDLE;
                            int_set[vam_pkg::IRQ_OFF_BIT] <= 1'b1;
                        end else if (hold_cnt_q + 1'b1 >= maxhold_q) begin
                            state_q    <= vam_pkg::VAM_EXPIRED;
                            trip_clear <= 1'b1;
                            int_set[vam_pkg::IRQ_EXP_BIT] <= 1'b1;
                        end else begin
                            hold_cnt_q <= hold_cnt_q + 1'b1;
                        end
                    end
                    vam_pkg::VAM_EXPIRED: begin
                        // stays blocked until voltage returns or disabled
                        if (!en || !volt_low) begin
                            state_q <= vam_pkg::VAM_IDLE;
                        end
                    end
                    default: state_q <= vam_pkg::VAM_IDLE;
                endcase
            end
        end
    end

    // ---------------- reference outputs ----------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mem_active <= 1'b0;
            prot_block <= 1'b0;
            ref_amp    <= '0;
            ref_ang    <= '0;
        end else begin
            mem_active <= state_q == vam_pkg::VAM_ACTIVE;
            prot_block <= state_q == vam_pkg::VAM_EXPIRED;
            if (state_q == vam_pkg::VAM_ACTIVE) begin
                ref_amp <= thresh_q;
                ref_ang <= held_q;
            end else begin
                ref_amp <= volt_mag[0];
                ref_ang <= volt_ang;
            end
        end
    end

    assign status = {cur_high, prot_block, volt_low, armed, mem_active};

    logic unused_ok;
    assign unused_ok = ^{haddr[31:8], hsize, hwdata[31:16]};
endmodule // vam_angle_hold_unit

`default_nettype wire

// ==== rtl/vam_pkg.sv ====
// constants and types for the voltage angle hold unit
package vam_pkg;
    localparam int unsigned CLK_NS      = 20;
    localparam int unsigned CYCLE_NS    = 5_000_000;
    localparam int unsigned CYCLE_CLKS  = CYCLE_NS / CLK_NS;
    localparam int unsigned HEALTHY_MS  = 2500;
    localparam int unsigned HEALTHY_CYC =
        (HEALTHY_MS * 1000 + CYCLE_NS / 1000 - 1) / (CYCLE_NS / 1000);
    localparam int unsigned DW          = 16;
    localparam int unsigned NPH         = 3;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_THRESH   = 8'h04;
    localparam logic [7:0] OFS_MINCUR   = 8'h08;
    localparam logic [7:0] OFS_MAXHOLD  = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_INT_STAT = 8'h14;
    localparam logic [7:0] OFS_INT_EN   = 8'h18;
    localparam logic [7:0] OFS_INT_CLR  = 8'h1c;

    // control fields
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_CUR_BIT  = 1;
    localparam int unsigned CTRL_USED_LSB = 2;

    // reset values: 15.00 %Un, 1.00 xIn, 15.000 s in 5 ms steps
    localparam logic [4:0]    CTRL_RST    = 5'h1d;
    localparam logic [DW-1:0] THRESH_RST  = 16'h05dc;
    localparam logic [DW-1:0] MINCUR_RST  = 16'h0064;
    localparam logic [DW-1:0] MAXHOLD_RST = 16'h0bb8;

    // interrupt bits
    localparam int unsigned IRQ_ON_BIT  = 0;
    localparam int unsigned IRQ_OFF_BIT = 1;
    localparam int unsigned IRQ_EXP_BIT = 2;
    localparam int unsigned NIRQ        = 3;

    typedef enum logic [1:0] {
        VAM_IDLE,
        VAM_ACTIVE,
        VAM_EXPIRED
    } vam_state_t;
endpackage

// ==== test/vam_angle_hold_unit_monitor.sv ====
// port assertions for the voltage angle hold unit
`timescale 1ns/1ns
`default_nettype none
module vam_angle_hold_unit_monitor #(
    parameter int unsigned CYCLE_CLKS = 16
) (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                hold_block,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic                mem_active,
    input wire logic [15:0]         ref_amp,
    input wire logic [2:0][15:0]    ref_ang,
    input wire logic                prot_block,
    input wire logic                trip_clear
);
    int unsigned ph_q;
    int unsigned blk_q;
    // phase of the processing cycle, counted from reset release
    always_ff @(posedge sys_clk) begin
        if (!rst_n) ph_q <= 0;
        else ph_q <= (ph_q == CYCLE_CLKS - 1) ? 0 : ph_q + 1;
    end
    always_ff @(posedge sys_clk) begin
        blk_q <= (rst_n && hold_block) ? blk_q + 1 : 0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_pulse;
        trip_clear ##1 !trip_clear;
    endsequence
    sequence s_held;
        prot_block && !mem_active;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or erroring");
    a_amp_stable: assert property (mem_active && $past(mem_active)
        |-> $stable(ref_amp)) else $error("held amplitude moved");
    a_ang_frozen: assert property (mem_active && $past(mem_active)
        |-> $stable(ref_ang)) else $error("held angle moved");
    a_trip_single: assert property (trip_clear |-> s_pulse)
        else $error("trip clear longer than one clock");
    a_trip_blocks: assert property (trip_clear |-> ##[0:1] s_held)
        else $error("expiry did not block");
    a_trip_cause: assert property ($rose(trip_clear) |-> $past(mem_active))
        else $error("trip clear without active memory");
    a_tick_phase: assert property ($changed(mem_active)
        || $changed(prot_block) |-> ph_q <= 2)
        else $error("state moved off the cycle tick");
    // sync, one cycle to sample, one cycle for the fsm to act
    a_block_drops: assert property (blk_q > 2 * CYCLE_CLKS + 4
        |-> !mem_active) else $error("block did not end memory");
    a_active_clean: assert property (mem_active |-> !prot_block)
        else $error("active and blocked together");
endmodule // vam_angle_hold_unit_monitor
bind vam_angle_hold_unit vam_angle_hold_unit_monitor #(
    .CYCLE_CLKS(CYCLE_CLKS)) u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
    .hold_block(hold_block), .hreadyout(hreadyout), .hresp(hresp),
    .mem_active(mem_active), .ref_amp(ref_amp), .ref_ang(ref_ang),
    .prot_block(prot_block), .trip_clear(trip_clear));
`default_nettype wire

// ==== test/vam_angle_hold_unit_tb.sv ====
// self-checking bench for the voltage angle hold unit
`timescale 1ns/1ns
`default_nettype none
module vam_angle_hold_unit_tb;
    localparam int unsigned CC = 16;
    logic                sys_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                hsel = 1'b0;
    logic                hwrite = 1'b0;
    logic                hold_block = 1'b0;
    logic [1:0]          htrans = 2'h0;
    logic [31:0]         haddr = 32'h0;
    logic [31:0]         hwdata = 32'h0;
    logic [31:0]         rd;
    logic [47:0]         held;
    logic [2:0][15:0]    volt_mag = '0;
    logic [2:0][15:0]    volt_ang = '0;
    logic [2:0][15:0]    curr_mag = '0;
    wire logic           hreadyout, hresp, mem_active, prot_block;
    wire logic           trip_clear, irq, start_q;
    wire logic [31:0]    hrdata;
    wire logic [15:0]    ref_amp;
    wire logic [2:0][15:0] ref_ang;
    wire logic [7:0]     trips_q;
    int                  seed = 95513;
    int                  n_fail = 0;
    int                  total_checks = 0;
    always #10 sys_clk = ~sys_clk;
    vam_angle_hold_unit #(.CYCLE_CLKS(CC)) dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .volt_mag(volt_mag), .volt_ang(volt_ang), .curr_mag(curr_mag),
        .hold_block(hold_block), .mem_active(mem_active), .ref_amp(ref_amp),
        .ref_ang(ref_ang), .prot_block(prot_block), .trip_clear(trip_clear),
        .irq(irq));
    vam_stage_model u_stage (.sys_clk(sys_clk), .rst_n(rst_n),
        .mem_active(mem_active), .trip_clear(trip_clear),
        .prot_block(prot_block), .start_q(start_q), .trips_q(trips_q));
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_sig(input int w, input logic v);
        int k;
        k = 0;
        while (((w == 0) ? mem_active : prot_block) !== v && k < 9 * CC) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 9 * CC) begin
            chk("wait", 48'h1, 48'h0);
            test_done();
        end
    endtask
    // request held until hready seen high, data phase likewise
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1 && k < 9 * CC) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 9 * CC) begin
            chk("hready", 48'h1, 48'h0);
            test_done();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic ticks(input int n);
        repeat (n * CC) @(posedge sys_clk);
    endtask
    task automatic set_volt(input logic [2:0] low);
        for (int i = 0; i < 3; i++) begin
            volt_mag[i] <= low[i] ? 16'($unsigned($random(seed)) % 1500)
                                  : 16'(2000 + $unsigned($random(seed)) % 5000);
            volt_ang[i] <= 16'($unsigned($random(seed)) % 36000);
        end
    endtask
    function automatic logic exp_act(input logic armed, input logic [2:0] low,
                                     input logic cur_en, input logic cur_hi);
        return armed && (&low) && (!cur_en || cur_hi);
    endfunction
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        bus(0, vam_pkg::OFS_CTRL, 0);
        chk("ctrl", 48'h1d, 48'(rd));
        bus(0, vam_pkg::OFS_THRESH, 0);
        chk("thresh", 48'h5dc, 48'(rd));
        bus(0, 8'h24, 0);
        chk("unmapped", 48'h0, 48'(rd));
        bus(1, vam_pkg::OFS_INT_EN, 32'h7);
        set_volt(3'b000);
        ticks(400);
        set_volt(3'b111);
        ticks(3);
        chk("early", 48'(exp_act(0, 3'b111, 0, 0)), 48'(mem_active));
        set_volt(3'b000);
        ticks(502);
        held = volt_ang;
        set_volt(3'b011);
        ticks(3);
        chk("part", 48'(exp_act(1, 3'b011, 0, 0)), 48'(mem_active));
        set_volt(3'b111);
        wait_sig(0, 1'b1);
        chk("amp", 48'(vam_pkg::THRESH_RST), 48'(ref_amp));
        chk("ang", held, ref_ang);
        chk("irq", 48'h1, 48'(irq));
        hold_block <= 1'b1;
        wait_sig(0, 1'b0);
        bus(0, vam_pkg::OFS_INT_STAT, 0);
        chk("stat", 48'h3, 48'(rd));
        set_volt(3'b000);
        ticks(2);
        hold_block <= 1'b0;
        bus(1, vam_pkg::OFS_INT_CLR, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk("irqclr", 48'h0, 48'(irq));
        bus(1, vam_pkg::OFS_CTRL, 32'h1f);
        bus(1, vam_pkg::OFS_MAXHOLD, 32'h4);
        curr_mag <= {3{16'd50}};
        ticks(502);
        set_volt(3'b111);
        ticks(3);
        chk("curlow", 48'(exp_act(1, 3'b111, 1, 0)), 48'(mem_active));
        curr_mag[1] <= 16'd200;
        wait_sig(0, 1'b1);
        chk("curhi", 48'(exp_act(1, 3'b111, 1, 1)), 48'(mem_active));
        wait_sig(1, 1'b1);
        chk("trips", 48'h1, 48'(trips_q));
        chk("start", 48'h0, 48'(start_q));
        bus(1, vam_pkg::OFS_INT_EN, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk("irqmask", 48'h0, 48'(irq));
        bus(1, vam_pkg::OFS_CTRL, 32'h1c);
        wait_sig(1, 1'b0);
        chk("disable", 48'h0, 48'(mem_active));
        test_done();
    end
endmodule // vam_angle_hold_unit_tb
`default_nettype wire

// ==== test/vam_stage_model.sv ====
// directional stage stand-in that consumes the memory, trip clear and block flags
`timescale 1ns/1ns
`default_nettype none
module vam_stage_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       mem_active,
    input  wire logic       trip_clear,
    input  wire logic       prot_block,
    output logic            start_q,
    output logic [7:0]      trips_q
);
    // a pending start must not outlive the expiry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) start_q <= 1'b0;
        else if (trip_clear || prot_block) start_q <= 1'b0;
        else if (mem_active) start_q <= 1'b1;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) trips_q <= 8'h00;
        else if (trip_clear) trips_q <= trips_q + 8'h01;
    end
endmodule // vam_stage_model
`default_nettype wire
